// ==== rtl/mcw_consts.svh ====
// Constants for the fieldbus coil and multi-register write handler
// Overview of operation
// - Multi-register write request: address, 0x10, start, quantity, byte count, data, CRC.
// - Byte count must equal twice the register quantity.
// - Slave address lies in 1..247 and must match the configured address.
// - Multi-register write reply: address, 0x10, start, quantity written, CRC.
// - Every frame ends in a 16-bit CRC, low byte first.
// - Sixteen-bit values travel high byte first.
// - Register 0x0000 is the first analog output; writes ascend through outputs.
// - Bit-mapped addresses reach downstream slave points through stored mapping.
// - Read-coils request: address, 0x01, start, bit quantity, CRC.
// - Read-coils reply: address, 0x01, byte count, packed bits, CRC.
// - First requested bit is LSB of first byte; 1 closed, 0 open.
// - Unused bits of the last reply byte are zero.
// - Coil write needs mapping with slave function 01; changes go downstream.
// - Write-single-coil request: address, 0x05, mapped address, value, CRC.
// - Coil value is 0xFF00 for 1 or 0x0000 for 0, nothing else.
// - Single-coil reply echoes address, 0x05, mapped address, value, CRC.
`ifndef MCW_CONSTS_SVH
`define MCW_CONSTS_SVH

`define MCW_FC_READ_COILS 8'h01
`define MCW_FC_WRITE_COIL 8'h05
`define MCW_FC_WRITE_MULTI 8'h10
`define MCW_SLAVE_FUNC_COIL 8'h01
`define MCW_COIL_ON 16'hff00
`define MCW_COIL_OFF 16'h0000
`define MCW_ADDR_MIN 8'h01
`define MCW_ADDR_MAX 8'hf7
`define MCW_CRC_INIT 16'hffff
`define MCW_CRC_POLY 16'ha001
`define MCW_SHORT_REQ_LEN 8'h08
`define MCW_MULTI_HDR_LEN 9'h009
`define MCW_ECHO_REPLY_LEN 8'h06
`define MCW_COIL_REPLY_HDR 8'h03
`define MCW_MIN_FRAME_LEN 8'h04
`define MCW_POS_ADDR 0
`define MCW_POS_FC 1
`define MCW_POS_START_HI 2
`define MCW_POS_START_LO 3
`define MCW_POS_QTY_HI 4
`define MCW_POS_QTY_LO 5
`define MCW_POS_BCOUNT 6
`define MCW_POS_DATA 7
`define MCW_AO_RESET 16'h0000

`endif

// ==== rtl/mcw_pkg.sv ====
// Types shared by the coil and multi-register write handler
package mcw_pkg;

    typedef enum logic [1:0] {
        MCW_S_RX,
        MCW_S_CHECK,
        MCW_S_AO_WR,
        MCW_S_TX
    } mcw_state_t;

    // One received byte or an end-of-frame marker
    typedef struct packed {
        logic valid;
        logic frame_end;
        logic [7:0] data;
    } mcw_rx_t;

    // Stored mapping of one bit-mapped address
    typedef struct packed {
        logic en;
        logic [7:0] func;
        logic [7:0] slave;
        logic [15:0] point;
    } mcw_map_t;

    // Write order to a downstream slave point
    typedef struct packed {
        logic [7:0] slave;
        logic [15:0] point;
        logic value;
    } mcw_dn_wr_t;

endpackage : mcw_pkg

// ==== rtl/mcw_handler.sv ====
// Request handler for read coils, write single coil and write multiple registers
`timescale 1ns/1ps
`include "mcw_consts.svh"

module mcw_handler
    import mcw_pkg::*;
#(
    parameter int NUM_AO = 2,
    parameter int NUM_COILS = 64,
    parameter int BUF_BYTES = 64
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] cfg_addr,
    input wire mcw_rx_t rx,
    output logic rx_busy,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic [NUM_AO-1:0][15:0] analog_out,
    input wire mcw_map_t [NUM_COILS-1:0] coil_map,
    input wire logic pt_upd_valid,
    input wire logic [15:0] pt_upd_index,
    input wire logic pt_upd_value,
    output logic dn_wr_valid,
    output mcw_dn_wr_t dn_wr
);

    localparam int CW = $clog2(NUM_COILS);

    mcw_state_t state_q;
    logic [7:0] buf_q [BUF_BYTES];
    logic [7:0] cnt_q;
    logic ovf_q;
    logic [15:0] rx_crc_q;
    logic [15:0] tx_crc_q;
    logic [7:0] rlen_q;
    logic [7:0] tx_pos_q;
    logic [15:0] wr_i_q;
    logic [NUM_COILS-1:0] coil_q;

    logic [15:0] start_w;
    logic [15:0] qty_w;
    logic [7:0] fc_w;
    logic [16:0] end_w;
    logic addr_ok;
    logic crc_ok;
    logic fc10_ok;
    logic fc01_ok;
    logic fc05_ok;
    logic coil_val;
    logic [7:0] rbyte;
    logic tx_adv;

    // Running CRC step, reflected form
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ `MCW_CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction : crc_step

    // Packed coil byte k of the read reply
    function automatic logic [7:0] coil_byte(input logic [NUM_COILS-1:0] coils, input logic [15:0] start,
                                             input logic [15:0] qty, input logic [7:0] k);
        logic [7:0] b;
        logic [16:0] idx;
        logic [16:0] abs_i;
        b = 8'h00;
        for (int i = 0; i < 8; i++) begin
            idx = {6'h00, k, 3'h0} + 17'(i);
            abs_i = {1'b0, start} + idx;
            if (idx < {1'b0, qty}) begin
                b[i] = coils[abs_i[CW-1:0]];
            end else begin
                b[i] = 1'b0;
            end
        end
        return b;
    endfunction : coil_byte

    assign fc_w = buf_q[`MCW_POS_FC];
    assign start_w = {buf_q[`MCW_POS_START_HI], buf_q[`MCW_POS_START_LO]};
    assign qty_w = {buf_q[`MCW_POS_QTY_HI], buf_q[`MCW_POS_QTY_LO]};
    assign end_w = {1'b0, start_w} + {1'b0, qty_w};

    // Frame acceptance: checked once the frame has ended
    assign addr_ok = (cfg_addr >= `MCW_ADDR_MIN) && (cfg_addr <= `MCW_ADDR_MAX)
                     && (buf_q[`MCW_POS_ADDR] == cfg_addr);
    // Feeding the CRC bytes through the CRC leaves zero when the low byte came first
    assign crc_ok = !ovf_q && (cnt_q >= `MCW_MIN_FRAME_LEN) && (rx_crc_q == 16'h0000);

    assign fc10_ok = (fc_w == `MCW_FC_WRITE_MULTI)
                     && ({1'b0, cnt_q} == `MCW_MULTI_HDR_LEN + {1'b0, buf_q[`MCW_POS_BCOUNT]})
                     && ({9'h000, buf_q[`MCW_POS_BCOUNT]} == {qty_w, 1'b0})
                     && (qty_w != 16'h0000)
                     && (end_w <= 17'(NUM_AO));
    assign fc01_ok = (fc_w == `MCW_FC_READ_COILS) && (cnt_q == `MCW_SHORT_REQ_LEN)
                     && (qty_w != 16'h0000) && (end_w <= 17'(NUM_COILS));
    assign coil_val = (qty_w == `MCW_COIL_ON);
    assign fc05_ok = (fc_w == `MCW_FC_WRITE_COIL) && (cnt_q == `MCW_SHORT_REQ_LEN)
                     && ((qty_w == `MCW_COIL_ON) || (qty_w == `MCW_COIL_OFF))
                     && ({1'b0, start_w} < 17'(NUM_COILS))
                     && coil_map[start_w[CW-1:0]].en
                     && (coil_map[start_w[CW-1:0]].func == `MCW_SLAVE_FUNC_COIL);

    // Reply body byte at the current position, before the CRC
    always_comb begin
        if ((fc_w == `MCW_FC_READ_COILS) && (tx_pos_q == 8'd2)) begin
            rbyte = rlen_q - `MCW_COIL_REPLY_HDR;
        end else if ((fc_w == `MCW_FC_READ_COILS) && (tx_pos_q >= `MCW_COIL_REPLY_HDR)) begin
            rbyte = coil_byte(coil_q, start_w, qty_w, tx_pos_q - `MCW_COIL_REPLY_HDR);
        end else begin
            // Echo of address, code, start and quantity or value
            rbyte = buf_q[tx_pos_q[2:0]];
        end
    end

    assign tx_adv = !tx_valid || tx_ready;
    assign rx_busy = (state_q != MCW_S_RX);

    // Sequencer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= MCW_S_RX;
        end else begin
            case (state_q)
                MCW_S_RX: begin
                    if (rx.frame_end) begin
                        state_q <= MCW_S_CHECK;
                    end
                end
                MCW_S_CHECK: begin
                    if (!(crc_ok && addr_ok)) begin
                        state_q <= MCW_S_RX;
                    end else if (fc10_ok) begin
                        state_q <= MCW_S_AO_WR;
                    end else if (fc01_ok || fc05_ok) begin
                        state_q <= MCW_S_TX;
                    end else begin
                        state_q <= MCW_S_RX;
                    end
                end
                MCW_S_AO_WR: begin
                    if (wr_i_q + 16'h0001 == qty_w) begin
                        state_q <= MCW_S_TX;
                    end
                end
                MCW_S_TX: begin
                    if (tx_adv && (tx_pos_q == rlen_q + 8'd2)) begin
                        state_q <= MCW_S_RX;
                    end
                end
                default: begin
                    state_q <= MCW_S_RX;
                end
            endcase
        end
    end

    // Receive buffer and running CRC
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_q <= 8'h00;
            ovf_q <= 1'b0;
            rx_crc_q <= `MCW_CRC_INIT;
        end else if (state_q == MCW_S_RX) begin
            if (rx.frame_end) begin
                // Counters are rearmed when the frame is released
            end else if (rx.valid) begin
                if ({24'h0, cnt_q} < BUF_BYTES) begin
                    buf_q[cnt_q[$clog2(BUF_BYTES)-1:0]] <= rx.data;
                    cnt_q <= cnt_q + 8'h01;
                end else begin
                    ovf_q <= 1'b1;
                end
                rx_crc_q <= crc_step(rx_crc_q, rx.data);
            end
        end else if (state_q == MCW_S_CHECK && !(crc_ok && addr_ok && (fc10_ok || fc01_ok || fc05_ok))) begin
            cnt_q <= 8'h00;
            ovf_q <= 1'b0;
            rx_crc_q <= `MCW_CRC_INIT;
        end else if (state_q == MCW_S_TX && tx_adv && (tx_pos_q == rlen_q + 8'd2)) begin
            cnt_q <= 8'h00;
            ovf_q <= 1'b0;
            rx_crc_q <= `MCW_CRC_INIT;
        end
    end

    // Analog outputs, ascending from the start register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_i_q <= 16'h0000;
            for (int i = 0; i < NUM_AO; i++) begin
                analog_out[i] <= `MCW_AO_RESET;
            end
        end else if (state_q == MCW_S_AO_WR) begin
            analog_out[start_w + wr_i_q] <= {buf_q[`MCW_POS_DATA + 2 * wr_i_q],
                                             buf_q[`MCW_POS_DATA + 2 * wr_i_q + 1]};
            wr_i_q <= wr_i_q + 16'h0001;
        end else begin
            wr_i_q <= 16'h0000;
        end
    end

    // Mapped point images and downstream write orders
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            coil_q <= '0;
            dn_wr_valid <= 1'b0;
            dn_wr <= '0;
        end else begin
            dn_wr_valid <= 1'b0;
            if (pt_upd_valid && ({1'b0, pt_upd_index} < 17'(NUM_COILS))) begin
                coil_q[pt_upd_index[CW-1:0]] <= pt_upd_value;
            end
            // A master write beats a polled update to the same point
            if (state_q == MCW_S_CHECK && crc_ok && addr_ok && fc05_ok) begin
                coil_q[start_w[CW-1:0]] <= coil_val;
                if (coil_q[start_w[CW-1:0]] != coil_val) begin
                    dn_wr_valid <= 1'b1;
                    dn_wr.slave <= coil_map[start_w[CW-1:0]].slave;
                    dn_wr.point <= coil_map[start_w[CW-1:0]].point;
                    dn_wr.value <= coil_val;
                end
            end
        end
    end

    // Reply length without the CRC
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rlen_q <= `MCW_ECHO_REPLY_LEN;
        end else if (state_q == MCW_S_CHECK) begin
            if (fc_w == `MCW_FC_READ_COILS) begin
                rlen_q <= `MCW_COIL_REPLY_HDR + 8'(({1'b0, qty_w} + 17'd7) >> 3);
            end else begin
                rlen_q <= `MCW_ECHO_REPLY_LEN;
            end
        end
    end

    // Transmit: body bytes, then CRC low and high
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_pos_q <= 8'h00;
            tx_crc_q <= `MCW_CRC_INIT;
        end else if (state_q == MCW_S_TX) begin
            if (tx_adv) begin
                if (tx_pos_q < rlen_q) begin
                    tx_data <= rbyte;
                    tx_crc_q <= crc_step(tx_crc_q, rbyte);
                    tx_valid <= 1'b1;
                end else if (tx_pos_q == rlen_q) begin
                    tx_data <= tx_crc_q[7:0];
                    tx_valid <= 1'b1;
                end else if (tx_pos_q == rlen_q + 8'd1) begin
                    tx_data <= tx_crc_q[15:8];
                    tx_valid <= 1'b1;
                end else begin
                    tx_valid <= 1'b0;
                end
                tx_pos_q <= tx_pos_q + 8'h01;
            end
        end else begin
            tx_valid <= 1'b0;
            tx_pos_q <= 8'h00;
            tx_crc_q <= `MCW_CRC_INIT;
        end
    end

endmodule : mcw_handler

// ==== verif/mcw_handler_chk.sv ====
// Protocol checker bound to the fieldbus request handler
`timescale 1ns/1ps
module mcw_handler_chk
    import mcw_pkg::*;
#(
    parameter int NUM_AO = 2
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] cfg_addr,
    input wire mcw_rx_t rx,
    input wire logic rx_busy,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic [NUM_AO-1:0][15:0] analog_out,
    input wire logic dn_wr_valid,
    input wire mcw_dn_wr_t dn_wr
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    AST_END_BUSY: assert property (rx.frame_end && !rx_busy |=> rx_busy)
        else $error("no busy after frame end");
    AST_TX_IN_BUSY: assert property (tx_valid |-> rx_busy)
        else $error("reply byte outside busy");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte not held");
    AST_TX_ADDR: assert property ($rose(tx_valid) |-> tx_data == cfg_addr)
        else $error("reply does not open with own address");
    AST_TX_RANGE: assert property (tx_valid |-> cfg_addr inside {[8'h01:8'hf7]})
        else $error("reply with address out of range");
    AST_DN_PULSE: assert property (dn_wr_valid |=> !dn_wr_valid)
        else $error("downstream order longer than one cycle");
    AST_DN_BUSY: assert property (dn_wr_valid |-> rx_busy)
        else $error("downstream order outside a frame");
    AST_DN_HOLD: assert property ($changed(dn_wr) |-> dn_wr_valid)
        else $error("downstream order changed without pulse");
    AST_AO_IDLE: assert property (!rx_busy |=> $stable(analog_out))
        else $error("analog output changed while idle");
    cover property (dn_wr_valid);
    cover property (tx_valid && !tx_ready);
    cover property (rx_busy && !tx_valid ##1 !rx_busy);
endmodule : mcw_handler_chk

bind mcw_handler mcw_handler_chk #(.NUM_AO(NUM_AO)) chk_u (.ref_clk, .reset, .cfg_addr, .rx, .rx_busy,
    .tx_valid, .tx_data, .tx_ready, .analog_out, .dn_wr_valid, .dn_wr);

// ==== verif/mcw_master.sv ====
// Behavioural fieldbus master that frames requests and collects replies
`timescale 1ns/1ps
module mcw_master
    import mcw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic slow,
    output mcw_rx_t rx,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] got[$];
    int cyc = 0;
    initial begin
        rx = '0;
        tx_ready = 1'b0;
    end
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc16
    // Bad flips one CRC bit; the end marker carries the inverse of the last byte, then data idles at the last byte
    task automatic send(input logic [7:0] f[$], input bit bad);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(posedge ref_clk);
            #1 rx = {1'b1, 1'b0, f[i]};
        end
        @(posedge ref_clk);
        #1 rx = {1'b0, 1'b1, ~rx.data};
        @(posedge ref_clk);
        #1 rx = {1'b0, 1'b0, ~rx.data};
    endtask : send
    always @(posedge ref_clk) begin
        if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
        cyc++;
        #1 tx_ready = !slow || cyc % 3 == 0;
    end
endmodule : mcw_master

// ==== verif/tb_top.sv ====
// Self-checking bench for the fieldbus request handler
`timescale 1ns/1ps
module tb_top;
    import mcw_pkg::*;
    typedef struct {
        logic [87:0] req;
        int rl;
        logic [47:0] rsp;
        int pl;
        bit bad;
        int dn;
    } mcw_row_t;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] cfg_addr = 8'h01;
    mcw_rx_t rx;
    logic rx_busy, tx_valid, tx_ready, dn_wr_valid;
    logic slow = 1'b0;
    logic [7:0] tx_data;
    logic [1:0][15:0] analog_out;
    mcw_map_t [63:0] coil_map = '0;
    logic pt_upd_valid = 1'b0;
    logic [15:0] pt_upd_index = 16'h0000;
    logic pt_upd_value = 1'b0;
    logic [9:0] pat = 10'h173;
    mcw_dn_wr_t dn_wr, dn_last;
    int bad_count = 0, compares = 0, cycles = 0, dn_cnt = 0;
    mcw_row_t rows[13];
    always #5 ref_clk = ~ref_clk;
    mcw_handler #(.NUM_AO(2), .NUM_COILS(64), .BUF_BYTES(64)) dut_u (.ref_clk, .reset, .cfg_addr, .rx, .rx_busy,
        .tx_valid, .tx_data, .tx_ready, .analog_out, .coil_map, .pt_upd_valid, .pt_upd_index, .pt_upd_value,
        .dn_wr_valid, .dn_wr);
    mcw_master m_u (.ref_clk, .slow, .rx, .tx_valid, .tx_data, .tx_ready);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task automatic run(input mcw_row_t r);
        logic [7:0] q[$], e[$];
        logic [15:0] c;
        int n;
        for (int i = r.rl - 1; i >= 0; i--) q.push_back(r.req[i*8+:8]);
        for (int i = r.pl - 1; i >= 0; i--) e.push_back(r.rsp[i*8+:8]);
        c = m_u.crc16(e);
        if (r.pl > 0) e = {e, c[7:0], c[15:8]};
        m_u.got.delete();
        m_u.send(q, r.bad);
        n = 0;
        while (rx_busy !== 1'b0 && n < 300) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("reply_len", e.size(), m_u.got.size());
        foreach (e[i]) chk("reply_byte", e[i], m_u.got[i]);
        chk("dn_count", r.dn, dn_cnt);
    endtask : run
    always @(posedge ref_clk) begin
        if (dn_wr_valid === 1'b1) begin
            dn_cnt++;
            dn_last = dn_wr;
        end
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        coil_map[2] = {1'b1, 8'h01, 8'h11, 16'h0020};
        coil_map[3] = {1'b1, 8'h03, 8'h11, 16'h0021};
        rows = '{
            '{88'h01100000000204006400c8, 11, 48'h011000000002, 6, 0, 0},
            '{88'h01010000000a, 6, 48'h0101027301, 5, 0, 0},
            '{88'h01050002ff00, 6, 48'h01050002ff00, 6, 0, 1},
            '{88'h010100000003, 6, 48'h01010107, 4, 0, 1},
            '{88'h01050002ff00, 6, 48'h01050002ff00, 6, 0, 1},
            '{88'h010500020000, 6, 48'h010500020000, 6, 0, 2},
            '{88'h010500021234, 6, 48'h0, 0, 0, 2},
            '{88'h01050003ff00, 6, 48'h0, 0, 0, 2},
            '{88'h02010000000a, 6, 48'h0, 0, 0, 2},
            '{88'h0110000000010411112222, 11, 48'h0, 0, 0, 2},
            '{88'h0110000100020411112222, 11, 48'h0, 0, 0, 2},
            '{88'h01100000000102ffff, 9, 48'h0, 0, 1, 2},
            '{88'h01100001000102abcd, 9, 48'h011000010001, 6, 0, 2}
        };
        repeat (4) @(posedge ref_clk);
        #1 reset = 1'b0;
        chk("analog_reset", 32'h0, analog_out);
        chk("tx_reset", 32'h0, tx_valid);
        chk("crc_ref", 32'h0000c841, 32'(m_u.crc16({8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02})));
        // Load point images for coils 0..9
        for (int i = 0; i < 10; i++) begin
            pt_upd_valid = 1'b1;
            pt_upd_index = 16'(i);
            pt_upd_value = pat[i];
            @(posedge ref_clk);
            #1;
        end
        pt_upd_valid = 1'b0;
        foreach (rows[i]) run(rows[i]);
        chk("analog_out", {16'habcd, 16'h0064}, analog_out);
        chk("dn_last", {8'h11, 16'h0020, 1'b0}, dn_last);
        slow = 1'b1;
        cfg_addr = 8'h2a;
        run('{88'h2a050002ff00, 6, 48'h2a050002ff00, 6, 0, 3});
        chk("dn_last", {8'h11, 16'h0020, 1'b1}, dn_last);
        cfg_addr = 8'h00;
        run('{88'h000100000001, 6, 48'h0, 0, 0, 3});
        // Reset in mid-run clears outputs, orders and point images
        cfg_addr = 8'h01;
        reset = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 reset = 1'b0;
        chk("analog_rst2", 32'h0, analog_out);
        chk("dn_wr_rst2", 32'h0, 32'(dn_wr));
        chk("busy_rst2", 32'h0, 32'({rx_busy, tx_valid, dn_wr_valid}));
        run('{88'h010100000003, 6, 48'h01010100, 4, 0, 3});
        // Frame shorter than four bytes is dropped although its CRC is right
        run('{88'h01, 1, 48'h0, 0, 0, 3});
        final_report();
    end
endmodule : tb_top
